// ===== core/fsh_pkg.sv
// Purpose: Shared constants for the framer signaling and highway control block.
// Assumes: 8-bit registers, each on one aligned word of a plain register port.
// Notes:   Offsets, field positions, reset values and divide ratios live here only.
package fsh_pkg;

  // Register word offsets on the register port.
  localparam logic [7:0] SIG_MODE_OFS   = 8'h00;
  localparam logic [7:0] HWY_COMMON_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS     = 8'h08;

  // Reset values of the two control registers.
  localparam logic [7:0] SIG_MODE_RST   = 8'h00;
  localparam logic [7:0] HWY_COMMON_RST = 8'h00;

  // Signaling mode control field positions.
  localparam int TRANSPARENT_BIT  = 0;
  localparam int STOMP_BIT        = 1;
  localparam int ASSOC_BIT        = 2;
  localparam int FREEZE_BIT       = 3;
  localparam int MOS_BIT          = 4;
  localparam int HYBRID_BIT       = 5;
  localparam int AUTO_AIS_BIT     = 6;
  localparam int SQUELCH_BIT      = 7;

  // Highway common control field positions.
  localparam int PLL_FREQ_BIT     = 0;
  localparam int CLK_MODE_BIT     = 1;
  localparam int RATE_LSB         = 2;
  localparam int RATE_MSB         = 3;

  // Highway data rate codes.
  localparam logic [1:0] RATE_2M048 = 2'h0;
  localparam logic [1:0] RATE_4M096 = 2'h1;
  localparam logic [1:0] RATE_8M192 = 2'h2;

  // Highway channel lengths in bits.
  localparam logic [4:0] CHAN_BITS_PLAIN = 5'h08;
  localparam logic [4:0] CHAN_BITS_ASSOC = 5'h10;

  // Reference edges per divided output period; the same in both frequency modes
  // because the high-frequency reference is four times faster and the output too.
  localparam logic [8:0] DIV_DS1  = 9'h0C1;
  localparam logic [8:0] DIV_CEPT = 9'h100;

  // Channel numbers with special roles (zero based).
  localparam logic [4:0] MOS_CHAN  = 5'h17;
  localparam logic [4:0] TS16_CHAN = 5'h10;

  // Patterns.
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [3:0] ABCD_ZERO = 4'h0;
  localparam logic [3:0] ABCD_ONES = 4'hF;

endpackage

// ===== core/fsh_core.sv
// Purpose: Signaling insertion/extraction and highway common control of one framer.
// Assumes: One byte per cycle on each stream; channel and frame position given by
//          the framer; the reference clock pin is asynchronous to clk.
// Notes:   Overview of operation
// Overview of operation
// - Signaling inserted and extracted unless transparent
// - Transparent mode passes every channel untouched
// - DS1 voice/data choice from F and G bits
// - Stomp clear forwards received signaling unchanged
// - DS1 stomp: capture, then force bits one
// - CEPT stomp: received ABCD 0000 becomes 1111
// - Associated mode: 16-bit highway channels
// - Freeze bit holds receive signaling buffer
// - DS1 message signaling uses channel 24
// - Hybrid: F/G from register, ABCD from highway
// - Hybrid: F/G copied to receive side
// - Auto AIS in system TS16 on multiframe loss
// - Squelch forces AIS into system TS16
// - Low-frequency reference gives 8 kHz output
// - High-frequency reference gives 32 kHz output
// - Clock mode clear: highway clock equals rate
// - Bits 2-3 select highway data rate
// - Both control registers reset to zero
`timescale 1ns/10ps
`default_nettype none

module fsh_core
  import fsh_pkg::*;
#(
  parameter int NUM_CH = 32
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       cept_mode,
  input  wire logic       tx_valid,
  input  wire logic [4:0] tx_chan,
  input  wire logic [7:0] tx_data,
  input  wire logic [7:0] tx_hwy_sig,
  input  wire logic [7:0] tx_reg_sig,
  input  wire logic [1:0] tx_reg_fg,
  input  wire logic       tx_rbs_frame,
  input  wire logic [1:0] tx_sig_sel,
  output logic            tx_out_valid,
  output logic      [7:0] tx_out_data,
  input  wire logic       rx_valid,
  input  wire logic [4:0] rx_chan,
  input  wire logic [7:0] rx_data,
  input  wire logic [1:0] rx_reg_fg,
  input  wire logic       rx_rbs_frame,
  input  wire logic [1:0] rx_sig_sel,
  input  wire logic [3:0] rx_mf_frame,
  input  wire logic       rx_ts16_mfa_lost,
  output logic            rx_out_valid,
  output logic      [7:0] rx_out_data,
  output logic      [7:0] rx_out_sig,
  input  wire logic       pll_reference_clock,
  output logic            divided_pll_output,
  output logic      [1:0] highway_rate_select,
  output logic      [4:0] hwy_channel_bits,
  output logic            hwy_clock_per_bit
);

  // The channel index is five bits wide, so more than 32 channels cannot be served.
  if (NUM_CH < 24 || NUM_CH > 32) begin : g_bad_num_ch
    $error("NUM_CH must lie between 24 and 32");
  end

  logic [7:0] sig_mode_q;
  logic [7:0] hwy_common_q;

  // Decoded control fields.
  logic transparent_signaling;
  logic stomp_mode;
  logic associated_signaling_mode;
  logic receive_signaling_freeze;
  logic message_oriented_signaling;
  logic register_framed_highway_abcd;
  logic auto_system_ts16_alarm;
  logic transmit_system_ts16_squelch;
  logic pll_reference_frequency_mode;
  logic highway_clock_mode;
  assign transparent_signaling        = sig_mode_q[TRANSPARENT_BIT];
  assign stomp_mode                   = sig_mode_q[STOMP_BIT];
  assign associated_signaling_mode    = sig_mode_q[ASSOC_BIT];
  assign receive_signaling_freeze     = sig_mode_q[FREEZE_BIT];
  assign message_oriented_signaling   = sig_mode_q[MOS_BIT];
  assign register_framed_highway_abcd = sig_mode_q[HYBRID_BIT];
  assign auto_system_ts16_alarm       = sig_mode_q[AUTO_AIS_BIT];
  assign transmit_system_ts16_squelch = sig_mode_q[SQUELCH_BIT];
  assign pll_reference_frequency_mode = hwy_common_q[PLL_FREQ_BIT];
  assign highway_clock_mode           = hwy_common_q[CLK_MODE_BIT];

  // Hybrid mode needs DS1, associated mode and its own bit together.
  logic hybrid_active;
  assign hybrid_active = !cept_mode && associated_signaling_mode
                         && register_framed_highway_abcd;

  // Control register writes; both registers come out of reset at zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      sig_mode_q   <= SIG_MODE_RST;
      hwy_common_q <= HWY_COMMON_RST;
    end else if (reg_wr) begin
      if (reg_addr == SIG_MODE_OFS) begin
        sig_mode_q <= reg_wdata;
      end
      if (reg_addr == HWY_COMMON_OFS) begin
        hwy_common_q <= reg_wdata;
      end
    end
  end

  // Rate select follows the common control register; channel length follows associated mode.
  assign highway_rate_select = hwy_common_q[RATE_MSB:RATE_LSB];
  assign hwy_channel_bits    = associated_signaling_mode ? CHAN_BITS_ASSOC
                                                         : CHAN_BITS_PLAIN;
  // Only the equal-rate clock mode exists; a set bit is reserved and treated alike.
  assign hwy_clock_per_bit   = 1'b1;

  // Flags a configuration the host must avoid: associated mode at 2.048 Mbit/s.
  logic rate_conflict;
  assign rate_conflict = associated_signaling_mode
                         && (highway_rate_select == RATE_2M048);

  logic ts16_alarm;
  assign ts16_alarm = cept_mode && (transmit_system_ts16_squelch
                      || (auto_system_ts16_alarm && rx_ts16_mfa_lost));

  // Read data stands the cycle after the strobe; unmapped words read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        SIG_MODE_OFS:   reg_rdata <= sig_mode_q;
        HWY_COMMON_OFS: reg_rdata <= hwy_common_q;
        STATUS_OFS:     reg_rdata <= {4'h0, ts16_alarm, hybrid_active,
                                      rate_conflict, divided_pll_output};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Reference pin synchroniser; only the second and third stages are compared.
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  logic ref_lvl_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      ref_lvl_q <= 1'b0;
    end else begin
      ref_s1_q <= pll_reference_clock;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      if (ref_s2_q == ref_s3_q) begin
        ref_lvl_q <= ref_s3_q;
      end
    end
  end

  logic ref_rise;
  assign ref_rise = (ref_s2_q == ref_s3_q) && ref_s3_q && !ref_lvl_q;

  // Divide-down: the same edge count yields 8 kHz from the low reference and
  // 32 kHz from the fourfold reference; the mode bit only names the expectation.
  logic [8:0] div_ratio;
  logic [8:0] div_cnt_q;
  assign div_ratio = cept_mode ? DIV_CEPT : DIV_DS1;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_q          <= 9'h000;
      divided_pll_output <= 1'b0;
    end else if (ref_rise) begin
      if (div_cnt_q >= div_ratio - 9'h001) begin
        div_cnt_q          <= 9'h000;
        divided_pll_output <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 9'h001;
        if (div_cnt_q == (div_ratio >> 1) - 9'h001) begin
          divided_pll_output <= 1'b0;
        end
      end
    end
  end

  // Transmit: voice channel test from the F and G bits; MESSAGE_ORIENTED_SIGNALING keeps channel 24 clear.
  logic       tx_voice;
  logic [3:0] tx_abcd;
  logic [7:0] tx_d;
  assign tx_voice = (tx_reg_fg != 2'h0)
                    && !(message_oriented_signaling && tx_chan == MOS_CHAN);
  assign tx_abcd  = associated_signaling_mode ? tx_hwy_sig[3:0]
                                              : tx_reg_sig[3:0];
  always_comb begin
    tx_d = tx_data;
    if (!transparent_signaling) begin
      if (cept_mode) begin
        if (tx_chan == TS16_CHAN) begin
          tx_d = associated_signaling_mode ? tx_hwy_sig : tx_reg_sig;
        end
      end else if (tx_voice && tx_rbs_frame) begin
        tx_d[0] = tx_abcd[tx_sig_sel];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_out_valid <= 1'b0;
      tx_out_data  <= 8'h00;
    end else begin
      tx_out_valid <= tx_valid;
      if (tx_valid) begin
        tx_out_data <= tx_d;
      end
    end
  end

  // Receive-side F and G table, loaded from the transmit registers in hybrid mode.
  logic [1:0] rx_fg_q [NUM_CH];
  logic [3:0] sig_buf_q [NUM_CH];
  logic [1:0] rx_fg;
  logic       rx_voice;
  assign rx_fg    = hybrid_active ? rx_fg_q[rx_chan] : rx_reg_fg;
  assign rx_voice = (rx_fg != 2'h0)
                    && !(message_oriented_signaling && rx_chan == MOS_CHAN);

  // CEPT TS16 nibbles with the stomp substitution applied.
  logic [3:0] ts16_hi;
  logic [3:0] ts16_lo;
  logic [4:0] mf_lo_idx;
  assign ts16_hi = (stomp_mode && rx_data[7:4] == ABCD_ZERO) ? ABCD_ONES
                                                              : rx_data[7:4];
  assign ts16_lo = (stomp_mode && rx_data[3:0] == ABCD_ZERO) ? ABCD_ONES
                                                              : rx_data[3:0];
  assign mf_lo_idx = {1'b1, rx_mf_frame};

  logic rx_sig_update;
  assign rx_sig_update = rx_valid && !transparent_signaling
                         && !receive_signaling_freeze;

  // One generate loop keeps the per-channel tables.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_fg_q[c]   <= 2'h0;
        sig_buf_q[c] <= 4'h0;
      end else begin
        if (hybrid_active && tx_valid && tx_chan == 5'(c)) begin
          rx_fg_q[c] <= tx_reg_fg;
        end
        if (rx_sig_update) begin
          if (cept_mode) begin
            if (rx_chan == TS16_CHAN && rx_mf_frame != 4'h0) begin
              if (5'(c) == {1'b0, rx_mf_frame}) begin
                sig_buf_q[c] <= ts16_hi;
              end
              if (5'(c) == mf_lo_idx) begin
                sig_buf_q[c] <= ts16_lo;
              end
            end
          end else if (rx_chan == 5'(c) && rx_voice && rx_rbs_frame) begin
            sig_buf_q[c][rx_sig_sel] <= rx_data[0];
          end
        end
      end
    end
  end

  // Packed copy of the signaling buffer, so one check can watch every channel at once.
  logic [4*NUM_CH-1:0] sig_buf_flat;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      sig_buf_flat[4*i +: 4] = sig_buf_q[i];
    end
  end

  // Receive byte toward the highway: stomp, TS16 alarm or untouched data.
  logic [7:0] rx_d;
  always_comb begin
    rx_d = rx_data;
    if (!transparent_signaling) begin
      if (cept_mode) begin
        if (rx_chan == TS16_CHAN) begin
          rx_d = stomp_mode ? {ts16_hi, ts16_lo} : rx_data;
          if (ts16_alarm) begin
            rx_d = ALL_ONES;
          end
        end
      end else if (stomp_mode && rx_voice && rx_rbs_frame) begin
        rx_d[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_out_valid <= 1'b0;
      rx_out_data  <= 8'h00;
      rx_out_sig   <= 8'h00;
    end else begin
      rx_out_valid <= rx_valid;
      if (rx_valid) begin
        rx_out_data <= rx_d;
        rx_out_sig  <= (associated_signaling_mode && !transparent_signaling)
                       ? {4'h0, sig_buf_q[rx_chan]} : 8'h00;
      end
    end
  end

  // Checks.
  a_reg_reset: assert property (@(posedge clk)
    $past(rst) |-> (sig_mode_q == 8'h00 && hwy_common_q == 8'h00))
    else $error("control registers not zero after reset");
  a_rate_field: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == HWY_COMMON_OFS |=> highway_rate_select == $past(reg_wdata[3:2]))
    else $error("rate select does not follow bits 2 and 3");
  a_transparent_pass: assert property (@(posedge clk) disable iff (rst)
    tx_valid && transparent_signaling |=> tx_out_data == $past(tx_data))
    else $error("transparent transmit byte altered");
  a_rx_pass: assert property (@(posedge clk) disable iff (rst)
    rx_valid && !stomp_mode && !ts16_alarm |=> rx_out_data == $past(rx_data))
    else $error("receive byte altered with stomp clear");
  a_ds1_stomp: assert property (@(posedge clk) disable iff (rst)
    rx_valid && !cept_mode && !transparent_signaling && stomp_mode && rx_voice
    && rx_rbs_frame |=> rx_out_data[0])
    else $error("robbed bit not forced to one");
  a_cept_stomp: assert property (@(posedge clk) disable iff (rst)
    rx_valid && cept_mode && !transparent_signaling && stomp_mode && !ts16_alarm
    && rx_chan == TS16_CHAN && rx_data[7:4] == 4'h0 |=> rx_out_data[7:4] == 4'hF)
    else $error("zero ABCD not replaced");
  a_freeze_hold: assert property (@(posedge clk) disable iff (rst)
    (receive_signaling_freeze && !reg_wr) [*2] |-> $stable(sig_buf_flat))
    else $error("signaling buffer changed while frozen");
  a_ts16_ais: assert property (@(posedge clk) disable iff (rst)
    rx_valid && cept_mode && !transparent_signaling && transmit_system_ts16_squelch
    && rx_chan == TS16_CHAN |=> rx_out_data == 8'hFF)
    else $error("system TS16 not all ones under squelch");
  a_auto_ais: assert property (@(posedge clk) disable iff (rst)
    rx_valid && cept_mode && !transparent_signaling && auto_system_ts16_alarm
    && rx_ts16_mfa_lost && rx_chan == TS16_CHAN |=> rx_out_data == 8'hFF)
    else $error("auto AIS missing in system TS16");
  a_rbs_insert: assert property (@(posedge clk) disable iff (rst)
    tx_valid && !cept_mode && !transparent_signaling && tx_voice && tx_rbs_frame
    |=> tx_out_data[0] == $past(tx_abcd[tx_sig_sel]))
    else $error("robbed bit not inserted");
  a_chan_bits: assert property (@(posedge clk) disable iff (rst)
    associated_signaling_mode |-> hwy_channel_bits == 5'h10)
    else $error("associated channel not 16 bits");
  a_div_bound: assert property (@(posedge clk) disable iff (rst)
    ref_rise ##1 $stable(cept_mode) |-> div_cnt_q < div_ratio)
    else $error("divider count out of range");

  c_hybrid: cover property (@(posedge clk) disable iff (rst) hybrid_active && rx_valid);
  c_stomp: cover property (@(posedge clk) disable iff (rst) stomp_mode && rx_valid);
  c_div: cover property (@(posedge clk) disable iff (rst) $rose(divided_pll_output));
  c_ais: cover property (@(posedge clk) disable iff (rst) ts16_alarm && rx_valid);
  c_freeze: cover property (@(posedge clk) disable iff (rst) receive_signaling_freeze && rx_valid);

endmodule

`default_nettype wire

// ===== testbench/fsh_hwy_model.sv
// Purpose: Highway-side partner that feeds transmit bytes and takes receive bytes.
// Assumes: One byte per valid; requests launched just after a rising clk edge.
// Notes:   Between bytes the data lines carry the inverse of the last byte.
`timescale 1ns/10ps
`default_nettype none

module fsh_hwy_model (
  input  wire logic       clk,
  output logic            tx_valid,
  output logic      [4:0] tx_chan,
  output logic      [7:0] tx_data,
  output logic      [7:0] tx_hwy_sig,
  input  wire logic       rx_out_valid,
  input  wire logic [7:0] rx_out_data,
  input  wire logic [7:0] rx_out_sig
);
  logic [7:0] rx_byte;
  logic [7:0] rx_sig;
  int         rx_seen;

  // Idle values at time zero.
  initial begin
    tx_valid   = 1'b0;
    tx_chan    = 5'h00;
    tx_data    = 8'hA5;
    tx_hwy_sig = 8'h5A;
  end

  // One byte, valid for exactly one edge; stale data is inverted so it never looks valid.
  task automatic send(input logic [4:0] ch, input logic [7:0] d, input logic [7:0] s);
    @(posedge clk);
    tx_valid   <= 1'b1;
    tx_chan    <= ch;
    tx_data    <= d;
    tx_hwy_sig <= s;
    @(posedge clk);
    tx_valid   <= 1'b0;
    tx_data    <= ~d;
    tx_hwy_sig <= ~s;
  endtask

  // A receive byte stands one cycle only, so it is caught here at once.
  always_ff @(posedge clk) begin
    if (rx_out_valid) begin
      rx_byte <= rx_out_data;
      rx_sig  <= rx_out_sig;
      rx_seen <= rx_seen + 1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/fsh_core_tb.sv
// Purpose: Self-checking bench for the signaling and highway control block.
// Assumes: Robbed signaling bit is the byte LSB; registers at the package offsets.
// Notes:   Divider periods are counted in reference rises seen on the pin itself.
`timescale 1ns/10ps
`default_nettype none

module fsh_core_tb
  import fsh_pkg::*;
;
  logic       clk, rst, reg_wr, reg_rd, cept_mode, tx_valid, tx_rbs_frame;
  logic       tx_out_valid, rx_valid, rx_rbs_frame, rx_ts16_mfa_lost, rx_out_valid;
  logic       pll_reference_clock, divided_pll_output, hwy_clock_per_bit, pll_prev;
  logic [1:0] tx_reg_fg, tx_sig_sel, rx_reg_fg, rx_sig_sel, highway_rate_select;
  logic [3:0] rx_mf_frame;
  logic [4:0] tx_chan, rx_chan, hwy_channel_bits;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, tx_hwy_sig, tx_reg_sig;
  logic [7:0] tx_out_data, rx_data, rx_out_data, rx_out_sig, rd_val;
  int         miscompares, checked, pcount, budget;

  fsh_core i_fsh_core (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cept_mode,
    .tx_valid, .tx_chan, .tx_data, .tx_hwy_sig, .tx_reg_sig, .tx_reg_fg, .tx_rbs_frame,
    .tx_sig_sel, .tx_out_valid, .tx_out_data, .rx_valid, .rx_chan, .rx_data, .rx_reg_fg,
    .rx_rbs_frame, .rx_sig_sel, .rx_mf_frame, .rx_ts16_mfa_lost, .rx_out_valid,
    .rx_out_data, .rx_out_sig, .pll_reference_clock, .divided_pll_output,
    .highway_rate_select, .hwy_channel_bits, .hwy_clock_per_bit
  );
  fsh_hwy_model i_fsh_hwy_model (
    .clk, .tx_valid, .tx_chan, .tx_data, .tx_hwy_sig, .rx_out_valid, .rx_out_data,
    .rx_out_sig
  );

  // System clock, and a reference pin offset so its phase is unrelated.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    pll_reference_clock = 1'b0;
    #3;
    forever #80 pll_reference_clock = ~pll_reference_clock;
  end

  // Single comparison helper for every kind of value.
  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Register port cycles; read data stand only in the cycle after the strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // Stream helpers: transmit through the partner, receive from the line side.
  task automatic tx_chk(input logic [4:0] ch, input logic [7:0] d, input logic [7:0] s,
                        input logic [7:0] exp);
    i_fsh_hwy_model.send(ch, d, s);
    #1;
    cmp("tx_out_valid", 9'h001, {8'h00, tx_out_valid});
    cmp("tx_out_data", {1'b0, exp}, {1'b0, tx_out_data});
  endtask
  task automatic rx_line(input logic [4:0] ch, input logic [7:0] d);
    int n0;
    n0 = i_fsh_hwy_model.rx_seen;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_chan  <= ch;
    rx_data  <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
    @(posedge clk);
    #1;
    cmp("rx_out_valid", 9'h001, 9'(i_fsh_hwy_model.rx_seen - n0));
  endtask
  task automatic rx_chk(input logic [4:0] ch, input logic [7:0] d, input logic [7:0] exp);
    rx_line(ch, d);
    cmp("rx_out_data", {1'b0, exp}, {1'b0, i_fsh_hwy_model.rx_byte});
  endtask
  task automatic fill(input logic [7:0] d);
    for (int i = 0; i < 4; i++) begin
      rx_sig_sel <= 2'(i);
      rx_line(5'h03, d);
    end
  endtask
  task automatic probe(input logic [7:0] exp);
    rx_rbs_frame <= 1'b0;
    rx_line(5'h03, 8'hAA);
    rx_rbs_frame <= 1'b1;
    cmp("rx_out_sig", {1'b0, exp}, {1'b0, i_fsh_hwy_model.rx_sig});
  endtask

  // Counts reference rises until the divided output reaches a level; bounded.
  task automatic until_div(input logic lvl);
    while (divided_pll_output !== lvl && budget > 0) begin
      @(posedge clk);
      #1;
      budget--;
      if (pll_reference_clock && !pll_prev) pcount++;
      pll_prev = pll_reference_clock;
    end
    if (budget <= 0) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  task automatic div_chk(input logic [8:0] exp);
    budget = 20000;
    until_div(1'b0);
    until_div(1'b1);
    pcount = 0;
    until_div(1'b0);
    until_div(1'b1);
    cmp("divider period", exp, 9'(pcount));
  endtask

  // Reset values, rate field, clock mode and an unmapped address.
  task automatic t_regs;
    rd(SIG_MODE_OFS);
    cmp("signaling_mode_control", 9'h000, {1'b0, rd_val});
    rd(HWY_COMMON_OFS);
    cmp("highway_common_control", 9'h000, {1'b0, rd_val});
    cmp("hwy_channel_bits", 9'h008, {4'h0, hwy_channel_bits});
    for (int c = 0; c < 3; c++) begin
      wr(HWY_COMMON_OFS, 8'(c << RATE_LSB));
      rd(HWY_COMMON_OFS);
      cmp("highway_rate_select", 9'(c), {7'h00, highway_rate_select});
    end
    cmp("hwy_clock_per_bit", 9'h001, {8'h00, hwy_clock_per_bit});
    wr(8'h0C, 8'hFF);
    rd(8'h0C);
    cmp("unmapped read", 9'h000, {1'b0, rd_val});
    wr(SIG_MODE_OFS, 8'hA5);
    rd(SIG_MODE_OFS);
    cmp("signaling_mode_control", 9'h0A5, {1'b0, rd_val});
  endtask

  // Divider in both reference modes and both line standards.
  task automatic t_div;
    wr(SIG_MODE_OFS, 8'h00);
    cept_mode <= 1'b0;
    wr(HWY_COMMON_OFS, 8'h00);
    div_chk(DIV_DS1);
    wr(HWY_COMMON_OFS, 8'h01);
    div_chk(DIV_DS1);
    cept_mode <= 1'b1;
    div_chk(DIV_CEPT);
  endtask

  // Insertion, data channels, pass-through, message channel and hybrid source.
  task automatic t_tx;
    cept_mode    <= 1'b0;
    tx_rbs_frame <= 1'b1;
    tx_reg_fg    <= 2'h1;
    wr(SIG_MODE_OFS, 8'h00);
    tx_chk(5'h05, 8'hFF, 8'h0F, 8'hFE);
    tx_reg_fg <= 2'h0;
    tx_chk(5'h05, 8'hFF, 8'h0F, 8'hFF);
    tx_reg_fg <= 2'h1;
    wr(SIG_MODE_OFS, 8'h01);
    tx_chk(5'h05, 8'hFF, 8'h0F, 8'hFF);
    wr(SIG_MODE_OFS, 8'h10);
    tx_chk(MOS_CHAN, 8'hFF, 8'h0F, 8'hFF);
    tx_chk(5'h05, 8'hFF, 8'h0F, 8'hFE);
    wr(HWY_COMMON_OFS, 8'h04);
    wr(SIG_MODE_OFS, 8'h24);
    rd(STATUS_OFS);
    cmp("status", 9'h002, {2'h0, rd_val[7:1]});
    tx_reg_sig <= 8'h0F;
    tx_chk(5'h05, 8'hFF, 8'h00, 8'hFE);
    tx_chk(5'h05, 8'hFE, 8'h0F, 8'hFF);
  endtask

  // Stomp in both standards and the two alarm sources on time slot 16.
  task automatic t_rx;
    cept_mode    <= 1'b0;
    rx_rbs_frame <= 1'b1;
    rx_reg_fg    <= 2'h1;
    wr(SIG_MODE_OFS, 8'h00);
    rx_chk(5'h03, 8'h00, 8'h00);
    wr(SIG_MODE_OFS, 8'h02);
    rx_chk(5'h03, 8'h00, 8'h01);
    cept_mode   <= 1'b1;
    rx_mf_frame <= 4'h1;
    rx_chk(TS16_CHAN, 8'h50, 8'h5F);
    rx_chk(TS16_CHAN, 8'h00, 8'hFF);
    wr(SIG_MODE_OFS, 8'h00);
    rx_chk(TS16_CHAN, 8'h00, 8'h00);
    wr(SIG_MODE_OFS, 8'h80);
    rd(STATUS_OFS);
    cmp("status", 9'h004, {2'h0, rd_val[7:1]});
    rx_chk(TS16_CHAN, 8'h5A, 8'hFF);
    wr(SIG_MODE_OFS, 8'h40);
    rx_chk(TS16_CHAN, 8'h5A, 8'h5A);
    rx_ts16_mfa_lost <= 1'b1;
    rx_chk(TS16_CHAN, 8'h5A, 8'hFF);
    rx_ts16_mfa_lost <= 1'b0;
  endtask

  // Receive buffer fills, holds while frozen, then updates again.
  task automatic t_freeze;
    cept_mode <= 1'b0;
    wr(HWY_COMMON_OFS, 8'h04);
    wr(SIG_MODE_OFS, 8'h04);
    fill(8'h01);
    cmp("hwy_channel_bits", 9'h010, {4'h0, hwy_channel_bits});
    probe(8'h0F);
    wr(SIG_MODE_OFS, 8'h0C);
    fill(8'h00);
    probe(8'h0F);
    wr(SIG_MODE_OFS, 8'h04);
    fill(8'h00);
    probe(8'h00);
  endtask

  // Main sequence: time-zero values, ten reset cycles, then the scenarios.
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, cept_mode, tx_rbs_frame, rx_valid, rx_rbs_frame} = 6'h00;
    {tx_reg_fg, tx_sig_sel, rx_reg_fg, rx_sig_sel} = 8'h00;
    {reg_addr, reg_wdata, tx_reg_sig, rx_data} = 32'h0000_0000;
    rx_chan = 5'h00;
    rx_mf_frame = 4'h0;
    rx_ts16_mfa_lost = 1'b0;
    pll_prev = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_div;
    t_tx;
    t_rx;
    t_freeze;
    report_and_stop;
  end
endmodule
`default_nettype wire
